// File: rtl/vref_ctrl_regs.vh
// Register offsets, field positions and reset values of the reference control block
`ifndef VREF_CTRL_REGS_VH
`define VREF_CTRL_REGS_VH
`define REG_TRIM_OFS 4'h0
`define REG_CTRL_OFS 4'h4
`define REG_POWER_OFS 4'h8
`define CTRL_EN_BIT 7
`define CTRL_STABLE_BIT 2
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0
`define MODE_BANDGAP 2'h0
`define MODE_LOWPOWER 2'h1
`define MODE_TIGHT 2'h2
`define MODE_RESERVED 2'h3
`define CTRL_RESET 8'h00
`define POWER_RESET 8'h00
`define POWER_KEEP_BIT 0
`define SYNC_FLUSH_COUNT 2'h3
`endif

// File: rtl/sync_2ff.v
// Two-stage level synchronizer
`timescale 1ns/1ps
module sync_2ff (
    input wire clk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg meta_reg;
    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= 1'b0;
            dout <= 1'b0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule // sync_2ff

// File: rtl/voltage_reference_control.v
// Wishbone register bank and analog enables for the bandgap voltage reference
// Functional notes
// - At reset the trim code register loads the factory trim input, not a constant.
// - The trim code goes to the analog reference unchanged as offset binary, one step per code.
// - With the enable bit 7 clear, bandgap and both buffers are off whatever the mode.
// - Mode 00 is bandgap only, 01 low-power buffer, 10 tight-regulation buffer, 11 reserved.
// - Stable flag at bit 2 reads high only once startup is done, low while disabled or unstable.
// - A mode change while enabled and stable leaves the stable flag set; a change to mode 11 turns the bandgap off and the flag drops with ready.
// - In bandgap-only mode the bandgap is on and both buffers are off.
// - The reference runs in run and wait modes and stays on in third stop mode if allowed.
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`include "vref_ctrl_regs.vh"
module voltage_reference_control (
    // System
    input wire SYS_CLK,
    input wire SYS_RST,
    // Wishbone slave
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire [3:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    // Factory trim and power mode
    input wire [7:0] FACTORY_TRIM,
    input wire THIRD_STOP_MODE,
    // Analog side
    input wire ANALOG_READY,
    output reg [7:0] TRIM_CODE,
    output reg BANDGAP_EN,
    output reg LOWPOWER_BUF_EN,
    output reg TIGHT_BUF_EN
);
    // Reset images of the control and power registers
    localparam [7:0] ctrl_rst_val = `CTRL_RESET;
    localparam [7:0] power_rst_val = `POWER_RESET;
    // Startup tracking states
    localparam [1:0] st_off = 2'h0;
    localparam [1:0] st_flush = 2'h1;
    localparam [1:0] st_wait = 2'h2;
    localparam [1:0] st_stable = 2'h3;

    // Software visible state
    reg [7:0] trim_reg;
    reg reference_enable_reg;
    reg [1:0] mode_reg;
    reg third_stop_keep_reg;
    reg stable_reg;
    reg stable_next;

    // Startup tracking
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [1:0] flush_reg;
    reg [1:0] flush_next;
    wire ready_sync;
    wire run_on;

    // Bus decode and strobes
    reg hit_trim;
    reg hit_ctrl;
    reg hit_power;
    wire req;
    wire wr_req;
    wire wr_trim;
    wire wr_ctrl;
    wire wr_power;
    reg [31:0] rdata_next;

    // Next values of the registered outputs
    reg ack_next;
    reg [31:0] dat_next;
    reg bg_next;
    reg lp_next;
    reg tr_next;

    // Unmapped addresses are acked, read zero and ignore writes
    always @* begin
        hit_trim = 1'b0;
        hit_ctrl = 1'b0;
        hit_power = 1'b0;
        if (WB_ADR_I == `REG_TRIM_OFS) begin
            hit_trim = 1'b1;
        end else if (WB_ADR_I == `REG_CTRL_OFS) begin
            hit_ctrl = 1'b1;
        end else if (WB_ADR_I == `REG_POWER_OFS) begin
            hit_power = 1'b1;
        end
    end

    // A request is taken once; the ack that follows blocks a second take
    assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    // Only byte lane 0 carries register bits
    assign wr_req = req & WB_WE_I & WB_SEL_I[0];
    assign wr_trim = wr_req & hit_trim;
    assign wr_ctrl = wr_req & hit_ctrl;
    assign wr_power = wr_req & hit_power;

    // Trim loads the factory value while reset is held (synchronous reset)
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            trim_reg <= FACTORY_TRIM;
        end else if (wr_trim) begin
            trim_reg <= WB_DAT_I[7:0];
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            reference_enable_reg <= ctrl_rst_val[`CTRL_EN_BIT];
        end else if (wr_ctrl) begin
            reference_enable_reg <= WB_DAT_I[`CTRL_EN_BIT];
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            mode_reg <= ctrl_rst_val[`CTRL_MODE_HI:`CTRL_MODE_LO];
        end else if (wr_ctrl) begin
            mode_reg <= WB_DAT_I[`CTRL_MODE_HI:`CTRL_MODE_LO];
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            third_stop_keep_reg <= power_rst_val[`POWER_KEEP_BIT];
        end else if (wr_power) begin
            third_stop_keep_reg <= WB_DAT_I[`POWER_KEEP_BIT];
        end
    end

    // In third stop mode the reference stays on only when software allowed it
    assign run_on = reference_enable_reg & (~THIRD_STOP_MODE | third_stop_keep_reg);

    sync_2ff u_ready_sync (
        .clk(SYS_CLK),
        .rst(SYS_RST),
        .din(ANALOG_READY),
        .dout(ready_sync)
    );

    // A ready level still in the synchronizer from an earlier turn-on must not set the
    // flag, so it is ignored until the pipe from enable to ready has refilled
    always @* begin
        state_next = state_reg;
        flush_next = flush_reg;
        case (state_reg)
            st_off: begin
                flush_next = `SYNC_FLUSH_COUNT;
                if (run_on) begin
                    state_next = st_flush;
                end
            end
            st_flush: begin
                if (!run_on) begin
                    state_next = st_off;
                end else if (flush_reg == 2'h0) begin
                    state_next = st_wait;
                end else begin
                    flush_next = flush_reg - 2'h1;
                end
            end
            st_wait: begin
                if (!run_on) begin
                    state_next = st_off;
                end else if (ready_sync) begin
                    state_next = st_stable;
                end
            end
            st_stable: begin
                // Mode is not looked at; the flag drops when ready falls, as after mode 11 turns the bandgap off, or when run_on falls
                if (!run_on) begin
                    state_next = st_off;
                end else if (!ready_sync) begin
                    state_next = st_wait;
                end
            end
            default: begin
                state_next = st_off;
            end
        endcase
    end

    always @* begin
        stable_next = (state_next == st_stable);
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            state_reg <= st_off;
            flush_reg <= `SYNC_FLUSH_COUNT;
        end else begin
            state_reg <= state_next;
            flush_reg <= flush_next;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            stable_reg <= 1'b0;
        end else begin
            stable_reg <= stable_next;
        end
    end

    // Read data of the addressed register; upper bits read zero
    always @* begin
        rdata_next = 32'h00000000;
        if (hit_trim) begin
            rdata_next[7:0] = trim_reg;
        end else if (hit_ctrl) begin
            rdata_next[`CTRL_EN_BIT] = reference_enable_reg;
            rdata_next[`CTRL_STABLE_BIT] = stable_reg;
            rdata_next[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode_reg;
        end else if (hit_power) begin
            rdata_next[`POWER_KEEP_BIT] = third_stop_keep_reg;
        end
    end

    // Bus answer: ack one cycle after the take, data only while ack stands
    always @* begin
        ack_next = req;
        dat_next = 32'h00000000;
        if (req) begin
            dat_next = rdata_next;
        end
    end

    // Reserved mode 11 leaves everything off, as safest choice
    always @* begin
        bg_next = 1'b0;
        lp_next = 1'b0;
        tr_next = 1'b0;
        if (run_on) begin
            case (mode_reg)
                `MODE_BANDGAP: begin
                    bg_next = 1'b1;
                end
                `MODE_LOWPOWER: begin
                    bg_next = 1'b1;
                    lp_next = 1'b1;
                end
                `MODE_TIGHT: begin
                    bg_next = 1'b1;
                    tr_next = 1'b1;
                end
                default: begin
                    bg_next = 1'b0;
                end
            endcase
        end
    end

    // Every output comes straight from a flip-flop
    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= ack_next;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_DAT_O <= dat_next;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            TRIM_CODE <= 8'h00;
        end else begin
            TRIM_CODE <= trim_reg;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            BANDGAP_EN <= 1'b0;
        end else begin
            BANDGAP_EN <= bg_next;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            LOWPOWER_BUF_EN <= 1'b0;
        end else begin
            LOWPOWER_BUF_EN <= lp_next;
        end
    end

    always @(posedge SYS_CLK) begin
        if (SYS_RST) begin
            TIGHT_BUF_EN <= 1'b0;
        end else begin
            TIGHT_BUF_EN <= tr_next;
        end
    end
endmodule // voltage_reference_control

// File: bench/bandgap_model.sv
// Behavioural analog bandgap: ready rises a fixed time after its enable
`timescale 1ns/1ps
module bandgap_model #(parameter int DLY = 20) (
    // Enable in, startup indication out
    input wire clk,
    input wire bg_en,
    output logic ready = 0
);
    int cnt = 0;
    // Ready drops at once on disable, so stale flags show up
    always @(posedge clk) begin
        cnt <= bg_en ? cnt + 1 : 0;
        ready <= bg_en && cnt >= DLY;
    end
endmodule // bandgap_model

// File: bench/vref_ctrl_sva.sv
// Port assertions for the reference control block
`timescale 1ns/1ps
module vref_ctrl_sva (
    // Clock and reset
    input wire SYS_CLK,
    input wire SYS_RST,
    // Wishbone
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire WB_WE_I,
    input wire WB_ACK_O,
    input wire [3:0] WB_ADR_I,
    input wire [3:0] WB_SEL_I,
    input wire [31:0] WB_DAT_I,
    input wire [31:0] WB_DAT_O,
    // Power mode and analog side
    input wire THIRD_STOP_MODE,
    input wire ANALOG_READY,
    input wire BANDGAP_EN,
    input wire LOWPOWER_BUF_EN,
    input wire TIGHT_BUF_EN,
    input wire [7:0] TRIM_CODE
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    wire tk = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire wt = tk && WB_WE_I && WB_SEL_I[0];
    wire rd4 = WB_ACK_O && !WB_WE_I && WB_ADR_I == 4'h4;
    function automatic [2:0] dec(input [7:0] d);
        dec = d[7] ? {d[1:0] != 2'h3, d[1:0] == 2'h1, d[1:0] == 2'h2} : 3'h0;
    endfunction
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("long ack");
    ack_time_a: assert property (tk |=> WB_ACK_O) else $error("late ack");
    trim_out_a: assert property (wt && WB_ADR_I == 4'h0 |=> ##1
        TRIM_CODE == $past(WB_DAT_I[7:0], 2)) else $error("trim output");
    buf_excl_a: assert property (!(LOWPOWER_BUF_EN && TIGHT_BUF_EN)) else $error("two buffers");
    buf_bg_a: assert property (LOWPOWER_BUF_EN || TIGHT_BUF_EN |-> BANDGAP_EN)
        else $error("buffer without bandgap");
    mode_dec_a: assert property (wt && WB_ADR_I == 4'h4 && !THIRD_STOP_MODE |=> ##1
        {BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN} == dec($past(WB_DAT_I[7:0], 2)))
        else $error("bad enables");
    // Ready passes two sync stages, the flag flop and the read data flop
    stable_src_a: assert property (rd4 && WB_DAT_O[2] |-> $past(ANALOG_READY, 4))
        else $error("flag before ready");
    stable_off_a: assert property (rd4 |-> !WB_DAT_O[2] || WB_DAT_O[7])
        else $error("flag while disabled");
endmodule // vref_ctrl_sva
bind voltage_reference_control vref_ctrl_sva chk (.SYS_CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I,
    .WB_WE_I, .WB_ACK_O, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .THIRD_STOP_MODE,
    .ANALOG_READY, .BANDGAP_EN, .LOWPOWER_BUF_EN, .TIGHT_BUF_EN, .TRIM_CODE);

// File: bench/tb_voltage_reference_control.sv
// Bench for the reference control register bank
`timescale 1ns/1ps
module tb_voltage_reference_control;
    logic SYS_CLK = 0, SYS_RST = 1, WB_CYC_I = 0, WB_STB_I = 0, WB_WE_I = 0;
    logic THIRD_STOP_MODE = 0, WB_ACK_O, ANALOG_READY, BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN;
    logic [3:0] WB_ADR_I = 0, WB_SEL_I = 4'hf, sel_v = 4'hf;
    logic [31:0] WB_DAT_I = 0, WB_DAT_O, q;
    logic [7:0] FACTORY_TRIM = 8'h5a, TRIM_CODE;
    int n_fail = 0, cmp_count = 0, i;
    voltage_reference_control dut (.SYS_CLK, .SYS_RST, .WB_CYC_I, .WB_STB_I, .WB_WE_I,
        .WB_ADR_I, .WB_SEL_I, .WB_DAT_I, .WB_DAT_O, .WB_ACK_O, .FACTORY_TRIM, .THIRD_STOP_MODE,
        .ANALOG_READY, .TRIM_CODE, .BANDGAP_EN, .LOWPOWER_BUF_EN, .TIGHT_BUF_EN);
    bandgap_model #(.DLY(20)) ana (.clk(SYS_CLK), .bg_en(BANDGAP_EN), .ready(ANALOG_READY));
    initial forever #4 SYS_CLK = ~SYS_CLK;
    task automatic chk(input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Classic cycle: hold until ack is sampled, then release for a cycle
    task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d);
        WB_CYC_I <= 1;
        WB_STB_I <= 1;
        WB_WE_I <= we;
        WB_SEL_I <= sel_v;
        WB_ADR_I <= a;
        WB_DAT_I <= d;
        do @(posedge SYS_CLK); while (WB_ACK_O !== 1'b1);
        q = WB_DAT_O;
        WB_CYC_I <= 0;
        WB_STB_I <= 0;
        @(posedge SYS_CLK);
    endtask
    task automatic wrap_up;
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        n_fail++;
        wrap_up();
    end
    initial begin
        repeat (12) @(posedge SYS_CLK);
        SYS_RST <= 0;
        @(posedge SYS_CLK);
        xfer(0, 4'h0, 0);
        chk(q, 32'h5a);
        chk(TRIM_CODE, 32'h5a);
        xfer(1, 4'h0, 32'h80);
        chk(TRIM_CODE, 32'h80);
        sel_v = 4'he;
        xfer(1, 4'h0, 32'hff);
        sel_v = 4'hf;
        xfer(0, 4'h0, 0);
        chk(q, 32'h80);
        chk(TRIM_CODE, 32'h80);
        xfer(1, 4'h4, 32'h80);
        xfer(0, 4'h4, 0);
        chk(q[2], 0);
        repeat (40) if (q[2] !== 1'b1) xfer(0, 4'h4, 0);
        chk(q[7:0], 32'h84);
        chk({BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN}, 3'b100);
        $display("startup test done");
        for (i = 1; i < 4; i++) begin
            xfer(1, 4'h4, 32'h80 + i);
            xfer(0, 4'h4, 0);
            if (i < 3) chk(q[2], 1);
            chk({BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN}, i == 1 ? 3'b110 : i == 2 ? 3'b101 : 0);
        end
        xfer(1, 4'h4, 32'h01);
        repeat (8) @(posedge SYS_CLK);
        xfer(0, 4'h4, 0);
        chk(q[7:0], 32'h01);
        chk({BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN}, 0);
        $display("mode test done");
        THIRD_STOP_MODE <= 1;
        xfer(1, 4'h4, 32'h82);
        chk(BANDGAP_EN, 0);
        xfer(1, 4'h8, 32'h1);
        chk({BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN}, 3'b101);
        THIRD_STOP_MODE <= 0;
        xfer(0, 4'h8, 0);
        chk(q, 32'h1);
        xfer(1, 4'hc, 32'hff);
        xfer(0, 4'hc, 0);
        chk(q, 0);
        $display("stop test done");
        FACTORY_TRIM <= 8'h3c;
        SYS_RST <= 1;
        repeat (3) @(posedge SYS_CLK);
        chk({BANDGAP_EN, LOWPOWER_BUF_EN, TIGHT_BUF_EN}, 0);
        SYS_RST <= 0;
        @(posedge SYS_CLK);
        xfer(0, 4'h0, 0);
        chk(q, 32'h3c);
        xfer(0, 4'h4, 0);
        chk(q, 0);
        $display("reset test done");
        wrap_up();
    end
endmodule // tb_voltage_reference_control
